// ---- hw/pvm_pkg.sv ----
// Constants for the transceiver vendor mode register bank
package pvm_pkg;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [4:0] IDX_MODE_CTRL   = 5'h11;
  localparam logic [4:0] IDX_SPECIAL     = 5'h12;
  localparam logic [4:0] IDX_IRQ_STATUS  = 5'h14;
  localparam logic [4:0] IDX_IRQ_MASK    = 5'h15;
  localparam logic [4:0] IDX_SYM_ERR_CNT = 5'h1A;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_EDPD      = 13;
  localparam int POS_LOOP      = 9;
  localparam int POS_ALT_IRQ   = 6;
  localparam int POS_ENERGY    = 1;
  localparam int POS_MC_SPARE  = 0;
  localparam int POS_RMII      = 14;
  localparam int POS_MODE_LO   = 5;
  localparam int POS_ADDR_LO   = 0;

  // Interrupt status bits
  localparam int IRQ_ENERGY_ON  = 0;
  localparam int IRQ_ENERGY_OFF = 1;
  localparam int IRQ_SYM_ERR    = 2;
  localparam int IRQ_CNT_WRAP   = 3;
  localparam int IRQ_BITS       = 4;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic        RST_EDPD     = 1'b0;
  localparam logic        RST_LOOP     = 1'b0;
  localparam logic        RST_ALT_IRQ  = 1'b0;
  localparam logic        RST_ENERGY   = 1'b1;
  localparam logic        RST_MC_SPARE = 1'b0;
  localparam logic        RST_RMII     = 1'b0;
  localparam logic [15:0] RST_SYM_CNT  = 16'h0000;
  localparam logic [3:0]  RST_IRQ      = 4'h0;

  localparam int  CLK_HZ            = 100_000_000;
  localparam int  ENERGY_TIMEOUT_MS = 256;
  localparam int  ENERGY_TIMEOUT_CYC =
    (ENERGY_TIMEOUT_MS * (CLK_HZ / 1000));
  localparam int  ENERGY_TMR_W      = 25;

endpackage

// ---- hw/pvm_regs.sv ----
// Vendor mode, special mode and symbol error registers of the PHY
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps

module pvm_regs
  import pvm_pkg::*;
#(
  parameter int TIMEOUT_CYC = ENERGY_TIMEOUT_CYC
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        SOFT_RST,
  input  wire logic [4:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [2:0]  STRAP_MODE,
  input  wire logic [4:0]  STRAP_ADDR,
  input  wire logic        ENERGY_DET,
  input  wire logic        SPEED_100,
  input  wire logic        PKT_ACTIVE,
  input  wire logic        SYM_INVALID,
  input  wire logic        ISOLATE,
  input  wire logic        RX_DV,
  input  wire logic [1:0]  RXD,
  output logic             LOOP_TX_EN,
  output logic      [1:0]  LOOP_TXD,
  output logic             MAC_OUT_EN,
  output logic             EDPD_EN,
  output logic             ALT_IRQ_SEL,
  output logic             RMII_SEL,
  output logic      [2:0]  OP_MODE,
  output logic      [4:0]  STATION_ADDR,
  output logic             ENERGY_PRESENT,
  output logic             IRQ
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << ENERGY_TMR_W))
  begin : g_bad_timeout
    $error("TIMEOUT_CYC out of range");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]              energy_sync;
    logic [1:0]              mode_sync0;
    logic [1:0]              mode_sync1;
    logic [1:0]              mode_sync2;
    logic [1:0]              addr_sync0;
    logic [1:0]              addr_sync1;
    logic [1:0]              addr_sync2;
    logic [1:0]              addr_sync3;
    logic [1:0]              addr_sync4;
    logic                    energy_detect_powerdown_en;
    logic                    line_side_loopback_en;
    logic                    alternate_irq_select;
    logic                    line_energy_present;
    logic                    mc_spare;
    logic                    reduced_interface_select;
    logic [2:0]              op_mode;
    logic [4:0]              station_address;
    logic [15:0]             bad_symbol_count;
    logic                    pkt_counted;
    logic [ENERGY_TMR_W-1:0] quiet_tmr;
    logic [IRQ_BITS-1:0]     irq_status;
    logic [IRQ_BITS-1:0]     irq_mask;
    logic [15:0]             rdata;
    logic                    loop_tx_en;
    logic [1:0]              loop_txd;
    logic                    mac_out_en;
    logic                    irq;
  } pvm_state_t;

  localparam logic [ENERGY_TMR_W-1:0] TMR_LAST =
    ENERGY_TMR_W'(TIMEOUT_CYC - 1);

  pvm_state_t st;
  pvm_state_t next_st;

  logic [2:0]          mode_pins;
  logic [4:0]          addr_pins;
  logic [IRQ_BITS-1:0] irq_set;
  logic                loop_on;
  logic                energy_s;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    irq_set = '0;

    // **************************************************************
    // Two-stage synchronisers for pins
    // **************************************************************
    next_st.energy_sync = {st.energy_sync[0], ENERGY_DET};
    next_st.mode_sync0  = {st.mode_sync0[0], STRAP_MODE[0]};
    next_st.mode_sync1  = {st.mode_sync1[0], STRAP_MODE[1]};
    next_st.mode_sync2  = {st.mode_sync2[0], STRAP_MODE[2]};
    next_st.addr_sync0  = {st.addr_sync0[0], STRAP_ADDR[0]};
    next_st.addr_sync1  = {st.addr_sync1[0], STRAP_ADDR[1]};
    next_st.addr_sync2  = {st.addr_sync2[0], STRAP_ADDR[2]};
    next_st.addr_sync3  = {st.addr_sync3[0], STRAP_ADDR[3]};
    next_st.addr_sync4  = {st.addr_sync4[0], STRAP_ADDR[4]};
    mode_pins = {st.mode_sync2[1], st.mode_sync1[1],
                 st.mode_sync0[1]};
    addr_pins = {st.addr_sync4[1], st.addr_sync3[1],
                 st.addr_sync2[1], st.addr_sync1[1],
                 st.addr_sync0[1]};
    energy_s  = st.energy_sync[1];

    // **************************************************************
    // Energy presence with quiet timeout
    // **************************************************************
    if (energy_s)
    begin
      next_st.quiet_tmr = '0;
      next_st.line_energy_present = 1'b1;
      if (!st.line_energy_present)
      begin
        irq_set[IRQ_ENERGY_ON] = 1'b1;
      end
    end
    else if (st.quiet_tmr == TMR_LAST)
    begin
      next_st.line_energy_present = 1'b0;
      if (st.line_energy_present)
      begin
        irq_set[IRQ_ENERGY_OFF] = 1'b1;
      end
    end
    else
    begin
      next_st.quiet_tmr = st.quiet_tmr + 1'b1;
    end

    // **************************************************************
    // Symbol error counting at SPEED_100 only, once per packet, every invalid cycle outside packets
    // **************************************************************
    if (!PKT_ACTIVE)
    begin
      next_st.pkt_counted = 1'b0;
    end
    if (SPEED_100 && SYM_INVALID &&
        !(PKT_ACTIVE && st.pkt_counted))
    begin
      next_st.bad_symbol_count = st.bad_symbol_count + 16'h0001;
      next_st.pkt_counted = PKT_ACTIVE;
      irq_set[IRQ_SYM_ERR] = 1'b1;
      if (st.bad_symbol_count == 16'hFFFF)
      begin
        irq_set[IRQ_CNT_WRAP] = 1'b1;
      end
    end

    // **************************************************************
    // Register writes
    // **************************************************************
    if (WR)
    begin
      case (ADDR)
        IDX_MODE_CTRL:
        begin
          next_st.energy_detect_powerdown_en = WDATA[POS_EDPD];
          next_st.line_side_loopback_en = WDATA[POS_LOOP];
          next_st.alternate_irq_select = WDATA[POS_ALT_IRQ];
          next_st.mc_spare = WDATA[POS_MC_SPARE];
        end
        IDX_SPECIAL:
        begin
          next_st.reduced_interface_select = WDATA[POS_RMII];
          next_st.op_mode = WDATA[POS_MODE_LO +: 3];
          next_st.station_address = WDATA[POS_ADDR_LO +: 5];
        end
        IDX_IRQ_STATUS:
        begin
          next_st.irq_status = st.irq_status & ~WDATA[IRQ_BITS-1:0];
        end
        IDX_IRQ_MASK:
        begin
          next_st.irq_mask = WDATA[IRQ_BITS-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // **************************************************************
    // Events win over a clear in the same cycle
    // **************************************************************
    next_st.irq_status = next_st.irq_status | irq_set;

    // **************************************************************
    // Register reads, data in the following cycle only
    // **************************************************************
    next_st.rdata = 16'h0000;
    if (RD)
    begin
      case (ADDR)
        IDX_MODE_CTRL:
        begin
          next_st.rdata[POS_EDPD] = st.energy_detect_powerdown_en;
          next_st.rdata[POS_LOOP] = st.line_side_loopback_en;
          next_st.rdata[POS_ALT_IRQ] = st.alternate_irq_select;
          next_st.rdata[POS_ENERGY] = st.line_energy_present;
          next_st.rdata[POS_MC_SPARE] = st.mc_spare;
        end
        IDX_SPECIAL:
        begin
          next_st.rdata[POS_RMII] = st.reduced_interface_select;
          next_st.rdata[POS_MODE_LO +: 3] = st.op_mode;
          next_st.rdata[POS_ADDR_LO +: 5] = st.station_address;
        end
        IDX_IRQ_STATUS:
        begin
          next_st.rdata[IRQ_BITS-1:0] = st.irq_status;
        end
        IDX_IRQ_MASK:
        begin
          next_st.rdata[IRQ_BITS-1:0] = st.irq_mask;
        end
        IDX_SYM_ERR_CNT:
        begin
          next_st.rdata = st.bad_symbol_count;
        end
        default:
        begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end

    // **************************************************************
    // Software reset: control, counter and interrupt registers only
    // **************************************************************
    if (SOFT_RST)
    begin
      next_st.energy_detect_powerdown_en = RST_EDPD;
      next_st.line_side_loopback_en = RST_LOOP;
      next_st.alternate_irq_select = RST_ALT_IRQ;
      next_st.mc_spare = RST_MC_SPARE;
      next_st.bad_symbol_count = RST_SYM_CNT;
      next_st.pkt_counted = 1'b0;
      next_st.irq_status = RST_IRQ;
      next_st.irq_mask = RST_IRQ;
      next_st.rdata = 16'h0000;
      next_st.reduced_interface_select = st.reduced_interface_select;
      next_st.op_mode = st.op_mode;
      next_st.station_address = st.station_address;
      next_st.line_energy_present = st.line_energy_present;
    end

    // **************************************************************
    // Hardware reset; synchronisers keep shifting
    // **************************************************************
    if (RST)
    begin
      next_st.energy_detect_powerdown_en = RST_EDPD;
      next_st.line_side_loopback_en = RST_LOOP;
      next_st.alternate_irq_select = RST_ALT_IRQ;
      next_st.mc_spare = RST_MC_SPARE;
      next_st.line_energy_present = RST_ENERGY;
      next_st.quiet_tmr = '0;
      next_st.reduced_interface_select = RST_RMII;
      next_st.op_mode = mode_pins;
      next_st.station_address = addr_pins;
      next_st.bad_symbol_count = RST_SYM_CNT;
      next_st.pkt_counted = 1'b0;
      next_st.irq_status = RST_IRQ;
      next_st.irq_mask = RST_IRQ;
      next_st.rdata = 16'h0000;
    end

    // **************************************************************
    // Far loopback path, not gated by isolate
    // **************************************************************
    loop_on = st.line_side_loopback_en && SPEED_100 &&
              st.reduced_interface_select;
    next_st.loop_tx_en = 1'b0;
    next_st.loop_txd   = 2'b00;
    next_st.mac_out_en = 1'b0;
    if (!RST)
    begin
      next_st.mac_out_en = !ISOLATE;
      if (loop_on)
      begin
        next_st.loop_tx_en = RX_DV;
        next_st.loop_txd   = RXD;
      end
    end

    // **************************************************************
    // Interrupt line
    // **************************************************************
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS)
  begin
    st <= next_st;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA          = st.rdata;
  assign LOOP_TX_EN     = st.loop_tx_en;
  assign LOOP_TXD       = st.loop_txd;
  assign MAC_OUT_EN     = st.mac_out_en;
  assign EDPD_EN        = st.energy_detect_powerdown_en;
  assign ALT_IRQ_SEL    = st.alternate_irq_select;
  assign RMII_SEL       = st.reduced_interface_select;
  assign OP_MODE        = st.op_mode;
  assign STATION_ADDR   = st.station_address;
  assign ENERGY_PRESENT = st.line_energy_present;
  assign IRQ            = st.irq;

endmodule

// ---- sim/pvm_regs_assertions.sv ----
// Checker for the vendor mode register bank
`timescale 1ns/10ps
module pvm_regs_checker
  import pvm_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        SOFT_RST,
  input wire logic [4:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        ENERGY_DET,
  input wire logic        SPEED_100,
  input wire logic        RMII_SEL,
  input wire logic        LOOP_TX_EN,
  input wire logic        EDPD_EN,
  input wire logic        ALT_IRQ_SEL,
  input wire logic [2:0]  OP_MODE,
  input wire logic [4:0]  STATION_ADDR,
  input wire logic        ENERGY_PRESENT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  wire mc_wr = WR && ADDR == IDX_MODE_CTRL && !SOFT_RST;
  wire sm_wr = WR && ADDR == IDX_SPECIAL && !SOFT_RST;

  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not idle");
  a_edpd_write: assert property (
    mc_wr |=> EDPD_EN == $past(WDATA[POS_EDPD]))
    else $error("power-down enable not written");
  a_alt_write: assert property (
    mc_wr |=> ALT_IRQ_SEL == $past(WDATA[POS_ALT_IRQ]))
    else $error("interrupt scheme not written");
  a_rmii_write: assert property (
    sm_wr |=> RMII_SEL == $past(WDATA[POS_RMII]))
    else $error("interface select not written");
  a_addr_write: assert property (
    sm_wr |=> {OP_MODE, STATION_ADDR} == $past(WDATA[7:0]))
    else $error("mode or address not written");
  a_loop_mii: assert property (!RMII_SEL |=> !LOOP_TX_EN)
    else $error("loopback active in MII mode");
  a_loop_speed: assert property (!SPEED_100 |=> !LOOP_TX_EN)
    else $error("loopback active at low speed");
  a_energy_rise: assert property (
    ENERGY_DET [*3] |=> ENERGY_PRESENT)
    else $error("energy flag late");
  a_soft_keep: assert property (
    SOFT_RST |=> $stable({RMII_SEL, OP_MODE, STATION_ADDR}))
    else $error("special modes lost on soft reset");
endmodule

bind pvm_regs pvm_regs_checker i_pvm_regs_checker (
  .CLK_SYS(CLK_SYS), .RST(RST), .SOFT_RST(SOFT_RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .ENERGY_DET(ENERGY_DET), .SPEED_100(SPEED_100), .RMII_SEL(RMII_SEL),
  .LOOP_TX_EN(LOOP_TX_EN), .EDPD_EN(EDPD_EN), .ALT_IRQ_SEL(ALT_IRQ_SEL),
  .OP_MODE(OP_MODE), .STATION_ADDR(STATION_ADDR),
  .ENERGY_PRESENT(ENERGY_PRESENT)
);

// ---- sim/pvm_smc_model.sv ----
// Station management master model for the register port
`timescale 1ns/10ps
module pvm_smc_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] rdata,
  output logic      [4:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd
);
  initial
  begin
    addr  = 5'h00;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask
endmodule

// ---- sim/pvm_regs_test.sv ----
// Self-checking bench for the vendor mode register bank
`timescale 1ns/10ps
module pvm_regs_test
  import pvm_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        soft_rst = 1'b0;
  logic        energy_det = 1'b1;
  logic        speed_100 = 1'b1;
  logic        pkt_active = 1'b0;
  logic        sym_invalid = 1'b0;
  logic        isolate = 1'b0;
  logic        rx_dv = 1'b0;
  logic [1:0]  rxd = 2'h0;
  logic [2:0]  strap_mode = 3'h5;
  logic [4:0]  strap_addr = 5'h13;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic        wr, rd, loop_tx_en, edpd_en, alt_irq, rmii_sel, energy, irq;
  logic [1:0]  loop_txd;
  logic        mac_out_en;
  logic [2:0]  op_mode;
  logic [4:0]  station_addr;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  pvm_smc_model i_pvm_smc_model (.clk_sys(clk_sys), .rdata(rdata),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  pvm_regs #(.TIMEOUT_CYC(20)) i_pvm_regs (.CLK_SYS(clk_sys), .RST(rst),
    .SOFT_RST(soft_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .STRAP_MODE(strap_mode), .STRAP_ADDR(strap_addr),
    .ENERGY_DET(energy_det), .SPEED_100(speed_100),
    .PKT_ACTIVE(pkt_active), .SYM_INVALID(sym_invalid),
    .ISOLATE(isolate), .RX_DV(rx_dv), .RXD(rxd), .LOOP_TX_EN(loop_tx_en),
    .LOOP_TXD(loop_txd), .MAC_OUT_EN(mac_out_en), .EDPD_EN(edpd_en),
    .ALT_IRQ_SEL(alt_irq), .RMII_SEL(rmii_sel), .OP_MODE(op_mode),
    .STATION_ADDR(station_addr), .ENERGY_PRESENT(energy), .IRQ(irq));

  task automatic report_and_stop();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_pvm_smc_model.read_reg(a, d);
    chk(d, e);
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    i_pvm_smc_model.write_reg(a, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic sym(input int n, input logic pkt);
    @(posedge clk_sys);
    pkt_active  <= pkt;
    sym_invalid <= 1'b1;
    repeat (n) @(posedge clk_sys);
    sym_invalid <= 1'b0;
    pkt_active  <= 1'b0;
  endtask

  task automatic hw_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  initial
  begin
    hw_reset();
    rchk(IDX_MODE_CTRL, 16'h0002);
    rchk(IDX_SPECIAL, 16'h00B3);
    chk(16'({op_mode, station_addr}), 16'h00B3);
    chk(16'(mac_out_en), 16'h0001);
    rchk(IDX_SYM_ERR_CNT, 16'h0000);
    rchk(5'h03, 16'h0000);
    wreg(IDX_MODE_CTRL, 16'hFFFF);
    rchk(IDX_MODE_CTRL, 16'h2243);
    chk(16'({edpd_en, alt_irq}), 16'h0003);
    wreg(IDX_SYM_ERR_CNT, 16'h1234);
    rchk(IDX_SYM_ERR_CNT, 16'h0000);
    rx_dv <= 1'b1;
    rxd   <= 2'h2;
    tick(2);
    chk(16'(loop_tx_en), 16'h0000);
    wreg(IDX_SPECIAL, 16'h4047);
    isolate <= 1'b1;
    tick(2);
    chk(16'({rmii_sel, op_mode, station_addr}), 16'h0147);
    chk(16'({loop_tx_en, loop_txd}), 16'h0006);
    chk(16'(mac_out_en), 16'h0000);
    speed_100 <= 1'b0;
    tick(2);
    chk(16'(loop_tx_en), 16'h0000);
    rx_dv     <= 1'b0;
    speed_100 <= 1'b1;
    soft_rst  <= 1'b1;
    tick(1);
    soft_rst  <= 1'b0;
    rchk(IDX_SPECIAL, 16'h4047);
    rchk(IDX_MODE_CTRL, 16'h0002);
    sym(3, 1'b0);
    sym(4, 1'b1);
    rchk(IDX_SYM_ERR_CNT, 16'h0004);
    rchk(IDX_SYM_ERR_CNT, 16'h0004);
    speed_100 <= 1'b0;
    sym(3, 1'b0);
    rchk(IDX_SYM_ERR_CNT, 16'h0004);
    speed_100 <= 1'b1;
    sym(65532, 1'b0);
    rchk(IDX_SYM_ERR_CNT, 16'h0000);
    sym(1, 1'b0);
    rchk(IDX_SYM_ERR_CNT, 16'h0001);
    rchk(IDX_IRQ_STATUS, 16'h000C);
    chk(16'(irq), 16'h0000);
    wreg(IDX_IRQ_MASK, 16'h0004);
    tick(2);
    chk(16'(irq), 16'h0001);
    wreg(IDX_IRQ_STATUS, 16'h0004);
    tick(2);
    chk(16'(irq), 16'h0000);
    rchk(IDX_IRQ_STATUS, 16'h0008);
    rchk(IDX_IRQ_MASK, 16'h0004);
    energy_det <= 1'b0;
    tick(40);
    chk(16'(energy), 16'h0000);
    rchk(IDX_MODE_CTRL, 16'h0000);
    rchk(IDX_IRQ_STATUS, 16'h000A);
    energy_det <= 1'b1;
    strap_mode <= 3'h3;
    strap_addr <= 5'h0A;
    tick(4);
    chk(16'(energy), 16'h0001);
    hw_reset();
    rchk(IDX_MODE_CTRL, 16'h0002);
    rchk(IDX_SPECIAL, 16'h006A);
    report_and_stop();
  end
endmodule
